// ===== verilog/sac_pkg.sv
// Shared constants for the converter sequencing control block.
// Assumes a 100 MHz core clock and an analog core with a start/done handshake.
package sac_pkg;
   localparam int CLK_MHZ = 100;
   localparam int MAX_RATE_KSPS = 100;
   // Least spacing between conversion starts, rounded up
   localparam int MIN_START_CYC = (CLK_MHZ * 1000 + MAX_RATE_KSPS - 1)
      / MAX_RATE_KSPS;
   localparam int SPACE_W = 10;
   localparam int RES_W = 12;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 16;
   // Trigger source codes
   localparam logic [1:0] TRIG_SW = 2'h0;
   localparam logic [1:0] TRIG_TMR2 = 2'h1;
   localparam logic [1:0] TRIG_TMR3 = 2'h2;
   localparam logic [1:0] TRIG_EXT = 2'h3;
   // Gain codes: 0.5,1,2,4,8,16
   localparam logic [2:0] GAIN_HALF = 3'h0;
   localparam logic [2:0] GAIN_MAX = 3'h5;
   localparam logic [2:0] GAIN_RST = 3'h1;
   // Channel 8 is the temperature sensor
   localparam logic [3:0] CH_TEMP = 4'h8;
   localparam logic [3:0] CH_MAX = 4'h8;
   typedef enum {SAC_IDLE, SAC_CONV} sac_state_t;
endpackage

// ===== verilog/sac_fifo.sv
// Result FIFO between the result latch and the reader.
// Assumes both sides run on the core clock.
module sac_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sac_fifo_st_t;
   sac_fifo_st_t st_r, st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready_out = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_out = (st_r.cnt != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[st_r.rp];

   always_comb begin
      st_nxt = st_r;
      if (push) st_nxt.wp = st_r.wp + 1'b1;
      if (pop) st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) st_r <= '0;
      else st_r <= st_nxt;
      if (push) mem[st_r.wp] <= in_data_in;
   end

   a_fifo_no_over: assert property (@(posedge core_clk_in) disable iff
      (rst_in) st_r.cnt == (AW+1)'(DEPTH) |=> st_r.cnt != '0)
      else $error("fifo count wrapped past full");
   a_fifo_bound: assert property (@(posedge core_clk_in) disable iff
      (rst_in) st_r.cnt <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule

// ===== verilog/sac_ctrl.sv
// Conversion sequencing and result handling around a SAR converter core.
// Assumes the analog core pulses conv_done_in with its result in the same
// cycle; trigger inputs are single-cycle pulses synchronous to the clock.
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int RES_BITS = sac_pkg::RES_W
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Configuration
   input wire logic enable_in,
   input wire logic [1:0] trig_sel_in,
   input wire logic [3:0] chan_sel_in,
   input wire logic [3:0] diff_pair_in,
   input wire logic [2:0] gain_sel_in,
   input wire logic left_just_in,
   input wire logic ext_ref_in,
   input wire logic [RES_BITS-1:0] win_lo_in,
   input wire logic [RES_BITS-1:0] win_hi_in,
   // Triggers and done flag clear
   input wire logic sw_start_in,
   input wire logic tmr2_ovf_in,
   input wire logic tmr3_ovf_in,
   input wire logic ext_start_in,
   input wire logic done_clr_in,
   // Analog core
   output logic conv_start_out,
   output logic core_pwr_out,
   output logic [3:0] mux_pos_out,
   output logic [3:0] mux_neg_out,
   output logic mux_diff_out,
   output logic [2:0] gain_out,
   output logic ref_ext_out,
   input wire logic conv_done_in,
   input wire logic [RES_BITS-1:0] conv_data_in,
   // Results
   output logic busy_out,
   output logic done_flag_out,
   output logic done_irq_out,
   output logic win_irq_out,
   output logic [7:0] res_hi_out,
   output logic [7:0] res_lo_out,
   // Result stream
   output logic res_valid_out,
   input wire logic res_ready_in,
   output logic [sac_pkg::FIFO_W-1:0] res_data_out
);
   import sac_pkg::*;

   typedef struct packed {
      sac_state_t state;
      logic [SPACE_W-1:0] space;
      logic [SPACE_W:0] since;
      logic done_flag;
      logic done_irq;
      logic win_irq;
      logic start;
      logic [FIFO_W-1:0] result;
      logic push;
      logic [3:0] pos;
      logic [3:0] neg;
      logic diff;
      logic [2:0] gain;
      logic ref_ext;
   } sac_st_t;

   sac_st_t st_r, st_nxt;
   logic trig;
   logic fifo_ready;

   // Place the result in a 16-bit word, right or left aligned
   function automatic logic [FIFO_W-1:0] justify(
      input logic [RES_BITS-1:0] d, input logic left);
      logic [FIFO_W-1:0] w;
      w = FIFO_W'(d);
      if (left) w = w << (FIFO_W - RES_BITS);
      return w;
   endfunction

   always_comb begin
      case (trig_sel_in)
         TRIG_SW: trig = sw_start_in;
         TRIG_TMR2: trig = tmr2_ovf_in;
         TRIG_TMR3: trig = tmr3_ovf_in;
         TRIG_EXT: trig = ext_start_in;
         default: trig = 1'b0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      st_nxt.done_irq = 1'b0;
      st_nxt.win_irq = 1'b0;
      st_nxt.push = 1'b0;
      if (st_r.space != '0) st_nxt.space = st_r.space - 1'b1;
      // Saturating age of the last start, kept for the spacing check
      if (st_r.start) st_nxt.since = '0;
      else if (st_r.since != '1) st_nxt.since = st_r.since + 1'b1;
      // Set wins over clear so a finishing conversion is never lost
      if (done_clr_in) st_nxt.done_flag = 1'b0;
      case (st_r.state)
         SAC_IDLE: begin
            // Full FIFO stalls new starts so no result is dropped
            // A push still in flight already holds the last free slot
            if (enable_in && trig && st_r.space == '0 && fifo_ready
               && !st_r.push) begin
               st_nxt.state = SAC_CONV;
               st_nxt.start = 1'b1;
               st_nxt.space = SPACE_W'(MIN_START_CYC - 1);
               // Mux and gain held stable for the whole conversion
               if (chan_sel_in > CH_MAX) st_nxt.pos = CH_TEMP;
               else st_nxt.pos = chan_sel_in;
               st_nxt.diff = chan_sel_in < CH_TEMP
                  && diff_pair_in[chan_sel_in[2:1]];
               st_nxt.neg = {chan_sel_in[3:1], 1'b1};
               if (st_nxt.diff) st_nxt.pos = {chan_sel_in[3:1], 1'b0};
               if (gain_sel_in > GAIN_MAX) st_nxt.gain = GAIN_MAX;
               else st_nxt.gain = gain_sel_in;
               st_nxt.ref_ext = ext_ref_in;
            end
         end
         SAC_CONV: begin
            // Triggers arriving here are simply not looked at
            if (conv_done_in) begin
               st_nxt.state = SAC_IDLE;
               st_nxt.done_flag = 1'b1;
               st_nxt.done_irq = 1'b1;
               st_nxt.result = justify(conv_data_in, left_just_in);
               st_nxt.push = 1'b1;
               st_nxt.win_irq = conv_data_in >= win_lo_in
                  && conv_data_in <= win_hi_in;
            end else if (!enable_in) begin
               st_nxt.state = SAC_IDLE;
            end
         end
         default: st_nxt.state = SAC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_r <= '0;
         st_r.state <= SAC_IDLE;
         st_r.gain <= GAIN_RST;
         st_r.since <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign conv_start_out = st_r.start;
   assign core_pwr_out = enable_in;
   assign mux_pos_out = st_r.pos;
   assign mux_neg_out = st_r.neg;
   assign mux_diff_out = st_r.diff;
   assign gain_out = st_r.gain;
   assign ref_ext_out = st_r.ref_ext;
   assign busy_out = (st_r.state == SAC_CONV);
   assign done_flag_out = st_r.done_flag;
   assign done_irq_out = st_r.done_irq;
   assign win_irq_out = st_r.win_irq;
   assign res_hi_out = st_r.result[15:8];
   assign res_lo_out = st_r.result[7:0];

   sac_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .in_valid_in(st_r.push),
      .in_ready_out(fifo_ready),
      .in_data_in(st_r.result),
      .out_valid_out(res_valid_out),
      .out_ready_in(res_ready_in),
      .out_data_out(res_data_out)
   );

   localparam int GAP = MIN_START_CYC - 1;
   a_start_spacing: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |=> !conv_start_out [*8])
      else $error("starts too close");
   a_start_gap_cnt: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |-> st_r.space == SPACE_W'(GAP))
      else $error("spacing counter not loaded");
   a_done_sets_flag: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && conv_done_in |=> done_flag_out
      && done_irq_out)
      else $error("done flag or request missing");
   a_flag_holds: assert property (@(posedge core_clk_in)
      disable iff (rst_in) done_flag_out && !done_clr_in |=> done_flag_out)
      else $error("done flag dropped without clear");
   a_no_start_off: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !enable_in |=> !conv_start_out)
      else $error("start while shut down");
   a_window_inside: assert property (@(posedge core_clk_in)
      disable iff (rst_in) win_irq_out |-> $past(conv_data_in) >=
      $past(win_lo_in) && $past(conv_data_in) <= $past(win_hi_in))
      else $error("window request outside limits");
   a_start_busy: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |-> busy_out)
      else $error("start without busy");
   a_gain_range: assert property (@(posedge core_clk_in)
      disable iff (rst_in) gain_out <= GAIN_MAX)
      else $error("gain code out of range");
   a_result_just: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && conv_done_in |=> {res_hi_out,
      res_lo_out} == justify($past(conv_data_in), $past(left_just_in)))
      else $error("result alignment wrong");

   a_start_age: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |->
      st_r.since >= (SPACE_W+1)'(GAP))
      else $error("start sooner than the least spacing");
   a_start_trig: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |->
      $past(trig) && $past(enable_in))
      else $error("start without a selected trigger");
   a_trig_taken: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !busy_out && enable_in && trig
      && st_r.space == '0 && fifo_ready && !st_r.push |=> conv_start_out)
      else $error("trigger in idle not taken");
   a_busy_no_start: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out |=> !conv_start_out)
      else $error("new start during a conversion");
   a_done_ends_busy: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && conv_done_in |=> !busy_out)
      else $error("busy held after done");
   a_irq_single: assert property (@(posedge core_clk_in)
      disable iff (rst_in) done_irq_out |=> !done_irq_out)
      else $error("done request longer than one cycle");
   a_irq_cause: assert property (@(posedge core_clk_in)
      disable iff (rst_in) done_irq_out |-> $past(busy_out)
      && $past(conv_done_in))
      else $error("done request without a finished conversion");
   a_abort_quiet: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && !enable_in && !conv_done_in
      |=> !busy_out && !done_irq_out)
      else $error("conversion kept running in shutdown");
   a_result_holds: assert property (@(posedge core_clk_in)
      disable iff (rst_in) !done_irq_out |->
      $stable({res_hi_out, res_lo_out}))
      else $error("result bytes changed without a done");
   a_push_room: assert property (@(posedge core_clk_in)
      disable iff (rst_in) st_r.push |-> fifo_ready)
      else $error("result pushed into a full buffer");
   a_setup_holds: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && !conv_start_out |->
      $stable({mux_pos_out, mux_neg_out, mux_diff_out, gain_out,
      ref_ext_out}))
      else $error("mux or gain moved during a conversion");
   a_chan_range: assert property (@(posedge core_clk_in)
      disable iff (rst_in) mux_pos_out <= CH_MAX)
      else $error("channel outside the nine inputs");
   a_temp_single: assert property (@(posedge core_clk_in)
      disable iff (rst_in) mux_pos_out == CH_TEMP |-> !mux_diff_out)
      else $error("temperature channel set differential");
   a_diff_pair: assert property (@(posedge core_clk_in)
      disable iff (rst_in) mux_diff_out |-> !mux_pos_out[0]
      && mux_pos_out < CH_TEMP && mux_neg_out == (mux_pos_out | 4'h1))
      else $error("differential pair not even and odd");
   a_diff_select: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |-> mux_diff_out ==
      ($past(chan_sel_in < CH_TEMP)
      && $past(diff_pair_in[chan_sel_in[2:1]])))
      else $error("pair mode not taken from its setting");
   a_ref_capture: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |->
      ref_ext_out == $past(ext_ref_in))
      else $error("reference choice not captured");
   a_gain_capture: assert property (@(posedge core_clk_in)
      disable iff (rst_in) conv_start_out |-> gain_out ==
      ($past(gain_sel_in) > GAIN_MAX ? GAIN_MAX : $past(gain_sel_in)))
      else $error("gain code not captured");
   a_win_hit: assert property (@(posedge core_clk_in)
      disable iff (rst_in) busy_out && conv_done_in
      && conv_data_in >= win_lo_in && conv_data_in <= win_hi_in
      |=> win_irq_out)
      else $error("window request missing for a result inside");

   c_conv_done: cover property (@(posedge core_clk_in)
      busy_out && conv_done_in);
   c_window_hit: cover property (@(posedge core_clk_in) win_irq_out);
   c_left_just: cover property (@(posedge core_clk_in)
      left_just_in && done_irq_out);
   c_fifo_full: cover property (@(posedge core_clk_in) !fifo_ready);
   c_diff_conv: cover property (@(posedge core_clk_in)
      conv_start_out && mux_diff_out);
endmodule

// ===== testbench/sac_ctrl_test.sv
// Self-checking bench for the converter sequencing control block.
// Drives every port itself and plays the analog core's done pulse.
module sac_ctrl_test import sac_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, en = 1, lj = 0, xr = 0, clr = 0, cd = 0, rdy = 1;
   logic sw = 0, t2 = 0, t3 = 0, ex = 0;
   logic [1:0] ts = 0;
   logic [3:0] ch = 0, dp = 0;
   logic [2:0] gs = 1;
   logic [11:0] lo = 12'h1f0, hi = 12'h730, cdat = 0;
   logic st, pw, md, rx, bz, df, di, wi, rv;
   logic [3:0] mp, mn;
   logic [2:0] go;
   logic [7:0] rh, rl;
   logic [15:0] rd;
   logic [15:0] q[$];
   int bad_count = 0, cmp_count = 0;

   sac_ctrl dut (.core_clk_in(clk), .rst_in(rst), .enable_in(en),
      .trig_sel_in(ts), .chan_sel_in(ch), .diff_pair_in(dp),
      .gain_sel_in(gs), .left_just_in(lj), .ext_ref_in(xr),
      .win_lo_in(lo), .win_hi_in(hi), .sw_start_in(sw),
      .tmr2_ovf_in(t2), .tmr3_ovf_in(t3), .ext_start_in(ex),
      .done_clr_in(clr), .conv_start_out(st), .core_pwr_out(pw),
      .mux_pos_out(mp), .mux_neg_out(mn), .mux_diff_out(md),
      .gain_out(go), .ref_ext_out(rx), .conv_done_in(cd),
      .conv_data_in(cdat), .busy_out(bz), .done_flag_out(df),
      .done_irq_out(di), .win_irq_out(wi), .res_hi_out(rh),
      .res_lo_out(rl), .res_valid_out(rv), .res_ready_in(rdy),
      .res_data_out(rd));

   initial forever #5 clk = ~clk;

   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One trigger pulse on the source picked by s, sampled one edge later
   task automatic pulse(input logic [1:0] s);
      @(posedge clk);
      ts <= s;
      {ex, t3, t2, sw} <= 4'h1 << s;
      @(posedge clk);
      {ex, t3, t2, sw} <= 4'h0;
      #1;
   endtask

   task automatic conv(input logic [1:0] s, input logic [11:0] d,
      input logic ok);
      logic [15:0] w;
      logic [4:0] m;
      pulse(s);
      // Settings given with the trigger are read once they have landed
      w = lj ? {d, 4'h0} : {4'h0, d};
      m = ch > 8 ? 5'h08 : (ch < 8 && dp[ch[2:1]]) ?
         {2'b10, ch[2:1], 1'b0} : {1'b0, ch};
      chk("start", st, ok);
      if (ok) begin
         chk("busy", bz, 1'b1);
         chk("gain", go, gs > 5 ? 3'h5 : gs);
         chk("ref", rx, xr);
         chk("mux", {md, mp}, m);
         if (m[4])
            chk("neg", mn, m[3:0] | 4'h1);
         pulse(s);
         chk("retrig", st, 1'b0);
         @(posedge clk);
         cd <= 1;
         cdat <= d;
         @(posedge clk);
         cd <= 0;
         #1;
         chk("done", {bz, di, df}, 3'h3);
         chk("win", wi, d >= lo && d <= hi);
         chk("res", {rh, rl}, w);
         if (!rdy)
            q.push_back(w);
         // Too soon after the last start, so it must be dropped
         pulse(s);
         chk("space", st, 1'b0);
         repeat (1000) @(posedge clk);
      end
   endtask

   initial begin
      #600us;
      bad_count++;
      end_sim();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      #1;
      chk("rst", {st, bz, df, di, wi, rv}, 16'h0);
      chk("rst_res", {rh, rl}, 16'h0);
      chk("rst_gain", go, 3'h1);
      dp <= 4'h5;
      // Gains 0..6, channels 3..9, both justifications and references
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         gs <= 3'(i);
         ch <= 4'(i + 3);
         lj <= i[0];
         xr <= i[1];
         conv(2'(i % 4), 12'(i * 12'h150 + 12'h0a0), 1'b1);
      end
      repeat (5) @(posedge clk);
      chk("sticky", df, 1'b1);
      @(posedge clk);
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      #1;
      chk("clear", df, 1'b0);
      en <= 0;
      conv(TRIG_SW, 12'h123, 1'b0);
      chk("pwr", pw, 1'b0);
      en <= 1;
      // Shutting down mid-conversion drops it with no done
      pulse(TRIG_SW);
      chk("abort_go", bz, 1'b1);
      en <= 0;
      @(posedge clk);
      #1;
      chk("abort", {bz, df, di}, 3'h0);
      en <= 1;
      repeat (1000) @(posedge clk);
      // Hold the stream so the result buffer fills and blocks starts
      rdy <= 0;
      for (int i = 0; i < 8; i++)
         conv(2'(i % 4), 12'(i * 12'h111 + 12'h005), 1'b1);
      conv(TRIG_TMR2, 12'h0ff, 1'b0);
      rdy <= 1;
      // Each word is read while it stands, then the next edge pops it
      repeat (8) begin
         chk("fifo_valid", rv, 1'b1);
         chk("fifo", rd, q.pop_front());
         @(posedge clk);
         #1;
      end
      chk("empty", rv, 1'b0);
      end_sim();
   end
endmodule
